/* File: core/acc_pkg.sv */
// constants shared by the result accumulator and alarm logic
package acc_pkg;
    // ------------------------------------------------------------
    // register offsets (plain register port, word addressed)
    // ------------------------------------------------------------
    localparam logic [3:0] OFS_CTRL   = 4'h0;
    localparam logic [3:0] OFS_STATUS = 4'h1;
    localparam logic [3:0] OFS_SUM    = 4'h2;
    localparam logic [3:0] OFS_LOWTH  = 4'h3;
    localparam logic [3:0] OFS_UPTH   = 4'h4;
    localparam logic [3:0] OFS_RESULT = 4'h5;
    localparam logic [3:0] OFS_CONV   = 4'h6;

    // ------------------------------------------------------------
    // control register fields
    // ------------------------------------------------------------
    localparam int CTRL_ACC_EN   = 0;
    localparam int CTRL_ALARM_EN = 1;
    localparam int CTRL_DITHER   = 2;
    localparam int CTRL_TEMP_SEL = 3;
    localparam int CTRL_AUTO_LSB = 4;
    localparam int CTRL_CNT_LSB  = 8;
    localparam int CTRL_BURST    = 7;

    // status register fields
    localparam int ST_SUM_FULL = 0;
    localparam int ST_LOWER    = 1;
    localparam int ST_UPPER    = 2;
    localparam int ST_BUSY     = 3;

    // ------------------------------------------------------------
    // widths and reset values
    // ------------------------------------------------------------
    localparam int RES_W  = 12;
    localparam int SUM_W  = 20;
    localparam int CNT_W  = 9;
    localparam int AUTO_W = 3;
    localparam logic [15:0] CTRL_RST  = 16'h0000;
    localparam logic [11:0] LOWTH_RST = 12'h000;
    localparam logic [11:0] UPTH_RST  = 12'hfff;

    // ------------------------------------------------------------
    // timing: conversion time and auto-rate periods
    // ------------------------------------------------------------
    localparam int CLK_NS     = 100;
    localparam int CONV_NS    = 1200;
    localparam int CONV_CYC   = (CONV_NS + CLK_NS - 1) / CLK_NS;
    localparam int AUTO_BASE  = 16;
    localparam int DITH_W     = 3;
endpackage

/* File: core/adc_acc.sv */
// result accumulator, alarm comparators and auto-convert control
//
// What this block does
// - 20-bit sum adds successive 12-bit results, count programmable up to 256
// - reaching the programmed count sets sum_full_flag in status
// - one finished sum per n samples, acting as averaging filter
// - internal dither option, used with the sum to gain resolution
// - when enabled, each new result compared to lower and upper thresholds
// - above upper sets upper_alarm_flag, below lower sets lower_alarm_flag
// - three-bit field enables auto conversion and picks its rate
// - temperature selection blocks auto and burst conversion
//
// The placing of the registers and the strobed register port were decided locally.
`timescale 1ns/1ps
module adc_acc
    import acc_pkg::*;
(
    input  wire logic        clk_sys,  // system clock, 10 MHz
    input  wire logic        rstn,     // sync reset, active low
    input  wire logic [3:0]  addr,     // register address
    input  wire logic [15:0] wdata,    // write data
    input  wire logic        wr,       // write strobe
    input  wire logic        rd,       // read strobe
    input  wire logic [11:0] sample,   // converter code, pin side
    output logic      [19:0] rdata,    // read data, one cycle later
    output logic             sum_full, // sum_full_flag mirror
    output logic             alarm     // either alarm flag set
);
    // ------------------------------------------------------------
    // input synchroniser for the converter code
    // ------------------------------------------------------------
    logic [11:0] smp1_ff, smp2_ff;
    always_ff @(posedge clk_sys) begin
        if (!rstn) begin
            smp1_ff <= 12'h000;
            smp2_ff <= 12'h000;
        end else begin
            smp1_ff <= sample;
            smp2_ff <= smp1_ff;
        end
    end

    conv_if cif ();
    conv_seq u_conv (
        .clk_sys (clk_sys),
        .rstn    (rstn),
        .sample  (smp2_ff),
        .cif     (cif)
    );

    // ------------------------------------------------------------
    // registers and state
    // ------------------------------------------------------------
    typedef enum logic [1:0] {ST_IDLE, ST_WAIT} conv_st_t;

    logic [15:0]      ctrl_ff, nxt_ctrl;
    logic [11:0]      lowth_ff, nxt_lowth;
    logic [11:0]      upth_ff, nxt_upth;
    logic [11:0]      last_ff, nxt_last;
    logic [SUM_W-1:0] sum_ff, nxt_sum;
    logic [CNT_W-1:0] cnt_ff, nxt_cnt;
    logic             full_ff, nxt_full;
    logic             low_ff, nxt_low;
    logic             up_ff, nxt_up;
    logic [19:0]      rdata_ff, nxt_rdata;
    logic             start_ff, nxt_start;
    logic [11:0]      rate_ff, nxt_rate;
    conv_st_t         st_ff, nxt_st;

    logic [CNT_W-1:0] target;
    logic [AUTO_W-1:0] auto_sel;
    logic             auto_ok;
    logic             one_shot;
    logic             clr_st;

    // programmed count field 0..255 means 1..256 samples
    assign target   = {1'b0, ctrl_ff[CTRL_CNT_LSB +: 8]} + 9'h001;
    assign auto_sel = ctrl_ff[CTRL_AUTO_LSB +: AUTO_W];
    // temperature measurement forbids auto and burst
    assign auto_ok  = (auto_sel != 3'h0) && !ctrl_ff[CTRL_TEMP_SEL];
    assign one_shot = wr && (addr == OFS_CONV);
    assign clr_st   = wr && (addr == OFS_STATUS);

    always_comb begin
        nxt_ctrl  = ctrl_ff;
        nxt_lowth = lowth_ff;
        nxt_upth  = upth_ff;
        nxt_last  = last_ff;
        nxt_sum   = sum_ff;
        nxt_cnt   = cnt_ff;
        nxt_full  = full_ff;
        nxt_low   = low_ff;
        nxt_up    = up_ff;
        nxt_rdata = 20'h00000;
        nxt_start = 1'b0;
        nxt_rate  = rate_ff;
        nxt_st    = st_ff;

        // ---------------- register writes ----------------
        if (wr) begin
            case (addr)
                OFS_CTRL: begin
                    nxt_ctrl = wdata;
                    // burst bit cannot be set during temperature mode
                    if (wdata[CTRL_TEMP_SEL]) begin
                        nxt_ctrl[CTRL_BURST] = 1'b0;
                    end
                end
                OFS_LOWTH: nxt_lowth = wdata[11:0];
                OFS_UPTH:  nxt_upth  = wdata[11:0];
                default: ;
            endcase
        end
        // write-one-to-clear on alarm flags
        if (clr_st && wdata[ST_LOWER]) begin
            nxt_low = 1'b0;
        end
        if (clr_st && wdata[ST_UPPER]) begin
            nxt_up = 1'b0;
        end

        // ---------------- read and consume the sum ----------------
        if (rd) begin
            case (addr)
                OFS_CTRL:   nxt_rdata = {4'h0, ctrl_ff};
                OFS_STATUS: nxt_rdata = {16'h0000,
                                         st_ff == ST_WAIT, up_ff,
                                         low_ff, full_ff};
                OFS_SUM:    nxt_rdata = sum_ff;
                OFS_LOWTH:  nxt_rdata = {8'h00, lowth_ff};
                OFS_UPTH:   nxt_rdata = {8'h00, upth_ff};
                OFS_RESULT: nxt_rdata = {8'h00, last_ff};
                default:    nxt_rdata = 20'h00000;
            endcase
            if (addr == OFS_SUM && full_ff) begin
                nxt_sum  = '0;
                nxt_cnt  = '0;
                nxt_full = 1'b0;
            end
        end

        // ---------------- conversion pacing ----------------
        case (st_ff)
            ST_IDLE: begin
                if (auto_ok) begin
                    // auto rate: period scales with field value
                    if (rate_ff == 12'h000) begin
                        nxt_start = 1'b1;
                        nxt_st    = ST_WAIT;
                        nxt_rate  = 12'(AUTO_BASE) * {9'h000, auto_sel};
                    end else begin
                        nxt_rate = rate_ff - 12'h001;
                    end
                end else if (one_shot) begin
                    nxt_start = 1'b1;
                    nxt_st    = ST_WAIT;
                end
            end
            ST_WAIT: begin
                if (cif.done) begin
                    nxt_st = ST_IDLE;
                end
            end
            default: nxt_st = ST_IDLE;
        endcase

        // ---------------- result handling ----------------
        if (cif.done) begin
            nxt_last = cif.result;
            // hold a full sum until it is read
            if (ctrl_ff[CTRL_ACC_EN] && !full_ff) begin
                nxt_sum = sum_ff + {8'h00, cif.result};
                nxt_cnt = cnt_ff + 9'h001;
                if (cnt_ff + 9'h001 == target) begin
                    nxt_full = 1'b1;
                end
            end
            // set wins over a clear in the same cycle
            if (ctrl_ff[CTRL_ALARM_EN]) begin
                if (cif.result > upth_ff) begin
                    nxt_up = 1'b1;
                end
                if (cif.result < lowth_ff) begin
                    nxt_low = 1'b1;
                end
            end
        end
    end

    always_ff @(posedge clk_sys) begin
        if (!rstn) begin
            ctrl_ff  <= CTRL_RST;
            lowth_ff <= LOWTH_RST;
            upth_ff  <= UPTH_RST;
            last_ff  <= 12'h000;
            sum_ff   <= '0;
            cnt_ff   <= '0;
            full_ff  <= 1'b0;
            low_ff   <= 1'b0;
            up_ff    <= 1'b0;
            rdata_ff <= 20'h00000;
            start_ff <= 1'b0;
            rate_ff  <= 12'h000;
            st_ff    <= ST_IDLE;
        end else begin
            ctrl_ff  <= nxt_ctrl;
            lowth_ff <= nxt_lowth;
            upth_ff  <= nxt_upth;
            last_ff  <= nxt_last;
            sum_ff   <= nxt_sum;
            cnt_ff   <= nxt_cnt;
            full_ff  <= nxt_full;
            low_ff   <= nxt_low;
            up_ff    <= nxt_up;
            rdata_ff <= nxt_rdata;
            start_ff <= nxt_start;
            rate_ff  <= nxt_rate;
            st_ff    <= nxt_st;
        end
    end

    assign cif.start  = start_ff;
    assign cif.dither = ctrl_ff[CTRL_DITHER];
    assign rdata      = rdata_ff;
    assign sum_full   = full_ff;

    logic alarm_ff;
    always_ff @(posedge clk_sys) begin
        if (!rstn) begin
            alarm_ff <= 1'b0;
        end else begin
            alarm_ff <= nxt_low | nxt_up;
        end
    end
    assign alarm = alarm_ff;

    // ------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rstn);

    a_full_on_count: assert property (
        cif.done && ctrl_ff[CTRL_ACC_EN] && !full_ff
        && (cnt_ff + 9'h001 == target) |=> full_ff)
        else $error("sum full flag not set at count");
    a_sum_adds: assert property (
        cif.done && ctrl_ff[CTRL_ACC_EN] && !full_ff && !rd
        |=> sum_ff == $past(sum_ff) + {8'h00, $past(cif.result)})
        else $error("sum did not add result");
    a_sum_holds: assert property (
        full_ff && !(rd && addr == OFS_SUM) |=> $stable(sum_ff))
        else $error("full sum changed before read");
    a_read_clears: assert property (
        rd && addr == OFS_SUM && full_ff
        |=> sum_ff == '0 && cnt_ff == '0 && !full_ff)
        else $error("read did not restart sum");
    a_upper_set: assert property (
        cif.done && ctrl_ff[CTRL_ALARM_EN] && cif.result > upth_ff
        |=> up_ff && alarm)
        else $error("upper alarm missed");
    a_lower_set: assert property (
        cif.done && ctrl_ff[CTRL_ALARM_EN] && cif.result < lowth_ff
        |=> low_ff && alarm)
        else $error("lower alarm missed");
    a_no_alarm_off: assert property (
        !ctrl_ff[CTRL_ALARM_EN] && !low_ff |=> !low_ff)
        else $error("lower alarm set while disabled");
    a_temp_blocks: assert property (
        ctrl_ff[CTRL_TEMP_SEL] && !one_shot && st_ff == ST_IDLE
        |=> !start_ff)
        else $error("auto start during temperature mode");
    a_count_bound: assert property (
        cnt_ff <= target)
        else $error("sample count passed target");
    a_auto_starts: assert property (
        auto_ok && st_ff == ST_IDLE && rate_ff == 12'h000
        |=> start_ff ##1 st_ff == ST_WAIT)
        else $error("auto mode did not start");

    c_full:  cover property (full_ff ##1 rd && addr == OFS_SUM);
    c_upper: cover property ($rose(up_ff));
    c_lower: cover property ($rose(low_ff));
    c_auto:  cover property (auto_ok && start_ff);
endmodule

/* File: core/conv_if.sv */
// conversion request and result carrier between control and converter
`timescale 1ns/1ps
interface conv_if;
    logic        start;
    logic        dither;
    logic        done;
    logic [11:0] result;

    modport ctrl (output start, output dither, input done, input result);
    modport conv (input start, input dither, output done, output result);
endinterface

/* File: core/conv_seq.sv */
// conversion sequencer: paces conversions and returns a result
`timescale 1ns/1ps
module conv_seq
    import acc_pkg::*;
(
    input  wire logic        clk_sys,  // system clock
    input  wire logic        rstn,     // sync reset, active low
    input  wire logic [11:0] sample,   // sampled converter code
    conv_if.conv             cif       // request and result
);
    // ------------------------------------------------------------
    // conversion timer and dither source
    // ------------------------------------------------------------
    logic [7:0]        tmr_ff, nxt_tmr;
    logic              busy_ff, nxt_busy;
    logic              done_ff, nxt_done;
    logic [11:0]       res_ff, nxt_res;
    logic [DITH_W-1:0] lfsr_ff, nxt_lfsr;
    logic [12:0]       dsum;

    always_comb begin
        nxt_tmr  = tmr_ff;
        nxt_busy = busy_ff;
        nxt_done = 1'b0;
        nxt_res  = res_ff;
        nxt_lfsr = {lfsr_ff[DITH_W-2:0], lfsr_ff[DITH_W-1] ^ lfsr_ff[1]};
        // small pseudo-random offset; saturate so dither never wraps
        dsum = {1'b0, sample} + {10'h000, lfsr_ff};
        if (busy_ff) begin
            if (tmr_ff == 8'h01) begin
                nxt_busy = 1'b0;
                nxt_done = 1'b1;
                if (cif.dither) begin
                    nxt_res = dsum[12] ? 12'hfff : dsum[11:0];
                end else begin
                    nxt_res = sample;
                end
            end
            nxt_tmr = tmr_ff - 8'h01;
        end else if (cif.start) begin
            nxt_busy = 1'b1;
            nxt_tmr  = 8'(CONV_CYC);
        end
    end

    always_ff @(posedge clk_sys) begin
        if (!rstn) begin
            tmr_ff  <= 8'h00;
            busy_ff <= 1'b0;
            done_ff <= 1'b0;
            res_ff  <= 12'h000;
            lfsr_ff <= 3'h1;
        end else begin
            tmr_ff  <= nxt_tmr;
            busy_ff <= nxt_busy;
            done_ff <= nxt_done;
            res_ff  <= nxt_res;
            lfsr_ff <= nxt_lfsr;
        end
    end

    assign cif.done   = done_ff;
    assign cif.result = res_ff;
endmodule

/* File: verification/tb.sv */
// self-checking bench for the result accumulator and alarm block
`timescale 1ns/1ps
module tb;
    import acc_pkg::*;
    // ------------------------------------------------------------
    // clock, reset and stimulus signals
    // ------------------------------------------------------------
    logic        clk_sys = 1'b0;
    logic        rstn    = 1'b0;
    logic [3:0]  addr    = 4'h0;
    logic [15:0] wdata   = 16'h0000;
    logic        wr      = 1'b0;
    logic        rd      = 1'b0;
    logic [11:0] sample  = 12'h000;
    logic [19:0] rdata;
    logic        sum_full;
    logic        alarm;
    int          miscompares = 0;
    int          checks      = 0;
    int          cycles      = 0;
    logic [19:0] d;

    adc_acc dut (
        .clk_sys  (clk_sys),
        .rstn     (rstn),
        .addr     (addr),
        .wdata    (wdata),
        .wr       (wr),
        .rd       (rd),
        .sample   (sample),
        .rdata    (rdata),
        .sum_full (sum_full),
        .alarm    (alarm)
    );

    initial begin
        forever #50 clk_sys = ~clk_sys;
    end

    // ------------------------------------------------------------
    // bus tasks and comparison
    // ------------------------------------------------------------
    task automatic chk(input string nm, input logic [19:0] e,
                       input logic [19:0] g);
        checks++;
        if (g !== e) begin
            miscompares++;
            $display("wrong value %s expected %h seen %h", nm, e, g);
        end
    endtask

    task automatic wreg(input logic [3:0] a, input logic [15:0] v);
        @(posedge clk_sys);
        wr    <= 1'b1;
        addr  <= a;
        wdata <= v;
        @(posedge clk_sys);
        wr    <= 1'b0;
    endtask

    // read data stands only in the cycle after the strobe
    task automatic rreg(input logic [3:0] a, output logic [19:0] v);
        @(posedge clk_sys);
        rd   <= 1'b1;
        addr <= a;
        @(posedge clk_sys);
        rd   <= 1'b0;
        @(negedge clk_sys);
        v = rdata;
        // hand back on a rising edge so callers drive pins there
        @(posedge clk_sys);
    endtask

    // settle the two-flop sample path, then one-shot conversions
    task automatic convs(input int n, input logic [11:0] s);
        sample <= s;
        repeat (4) @(posedge clk_sys);
        repeat (n) begin
            wreg(OFS_CONV, 16'h0000);
            repeat (CONV_CYC + 4) @(posedge clk_sys);
        end
    endtask

    // ------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------
    task automatic t_reset;
        rreg(OFS_CTRL, d);    chk("ctrl", {4'h0, CTRL_RST}, d);
        rreg(OFS_LOWTH, d);   chk("lowth", {8'h00, LOWTH_RST}, d);
        rreg(OFS_UPTH, d);    chk("upth", {8'h00, UPTH_RST}, d);
        rreg(OFS_STATUS, d);  chk("status", 20'h00000, d);
        wreg(4'hf, 16'hffff);
        rreg(4'hf, d);        chk("unmapped", 20'h00000, d);
        wreg(OFS_CONV, 16'h0000);
        rreg(OFS_STATUS, d);  chk("busy", 20'h00008, d & 20'h8);
        repeat (CONV_CYC + 4) @(posedge clk_sys);
        rreg(OFS_STATUS, d);  chk("idle", 20'h00000, d & 20'h8);
        $display("test reset done");
    endtask

    task automatic t_accum;
        wreg(OFS_CTRL, 16'h0301);
        convs(3, 12'h123);
        chk("full early", 20'h0, {19'h0, sum_full});
        convs(1, 12'h123);
        chk("full", 20'h1, {19'h0, sum_full});
        rreg(OFS_STATUS, d);  chk("st full", 20'h1, d & 20'h1);
        convs(1, 12'h7ff);
        rreg(OFS_SUM, d);     chk("sum4", 20'h0048c, d);
        rreg(OFS_STATUS, d);  chk("st clr", 20'h0, d & 20'h1);
        rreg(OFS_SUM, d);     chk("sum clr", 20'h0, d);
        $display("test accumulate done");
    endtask

    task automatic t_full256;
        wreg(OFS_CTRL, 16'hff01);
        convs(255, 12'hfff);
        chk("full 255", 20'h0, {19'h0, sum_full});
        convs(1, 12'hfff);
        rreg(OFS_SUM, d);     chk("sum256", 20'hfff00, d);
        chk("avg", 20'h00fff, d >> 8);
        $display("test count 256 done");
    endtask

    task automatic t_dither;
        wreg(OFS_CTRL, 16'hff05);
        convs(256, 12'h800);
        rreg(OFS_SUM, d);
        checks++;
        // an idle dither source would leave the sum exactly on code
        if (d <= 20'h80000 || d > 20'h80700) begin
            miscompares++;
            $display("wrong value dither sum expected 80001..80700 seen %h",
                     d);
        end
        $display("test dither done");
    endtask

    task automatic t_auto;
        int n;
        sample <= 12'h0a5;
        repeat (4) @(posedge clk_sys);
        wreg(OFS_CTRL, 16'h0711);
        n = 0;
        while (sum_full !== 1'b1 && n < 3000) begin
            @(posedge clk_sys);
            n++;
        end
        chk("auto full", 20'h1, {19'h0, sum_full});
        // keep the count field so the held count stays within target
        wreg(OFS_CTRL, 16'h0700);
        rreg(OFS_SUM, d);     chk("auto sum", 20'h00528, d);
        $display("test auto done");
    endtask

    task automatic t_temp;
        wreg(OFS_CTRL, 16'h0099);
        rreg(OFS_CTRL, d);    chk("burst", 20'h00019, d);
        sample <= 12'h321;
        repeat (300) @(posedge clk_sys);
        chk("no auto", 20'h0, {19'h0, sum_full});
        convs(1, 12'h321);
        rreg(OFS_SUM, d);     chk("one shot", 20'h00321, d);
        wreg(OFS_CTRL, 16'h0000);
        $display("test temperature done");
    endtask

    task automatic t_alarm;
        wreg(OFS_CTRL, 16'h0002);
        wreg(OFS_LOWTH, 16'h0100);
        wreg(OFS_UPTH, 16'h0800);
        convs(1, 12'h800);
        rreg(OFS_STATUS, d);  chk("at upper", 20'h0, d & 20'h6);
        convs(1, 12'h801);
        rreg(OFS_STATUS, d);  chk("upper", 20'h4, d & 20'h6);
        chk("alarm pin", 20'h1, {19'h0, alarm});
        rreg(OFS_RESULT, d);  chk("result", 20'h00801, d);
        wreg(OFS_STATUS, 16'h0004);
        convs(1, 12'h100);
        rreg(OFS_STATUS, d);  chk("at lower", 20'h0, d & 20'h6);
        convs(1, 12'h0ff);
        rreg(OFS_STATUS, d);  chk("lower", 20'h2, d & 20'h6);
        wreg(OFS_STATUS, 16'h0002);
        wreg(OFS_CTRL, 16'h0000);
        convs(1, 12'hfff);
        rreg(OFS_STATUS, d);  chk("disabled", 20'h0, d & 20'h6);
        chk("alarm off", 20'h0, {19'h0, alarm});
        $display("test alarms done");
    endtask

    // ------------------------------------------------------------
    // verdict and hang guard
    // ------------------------------------------------------------
    task automatic end_of_test;
        $display("checks %0d miscompares %0d", checks, miscompares);
        if (miscompares == 0 && checks > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask

    // all scenarios together need roughly 10000 cycles
    always @(posedge clk_sys) begin
        cycles <= cycles + 1;
        if (cycles == 60000) begin
            miscompares++;
            end_of_test();
        end
    end

    initial begin
        repeat (12) @(posedge clk_sys);
        rstn <= 1'b1;
        t_reset();
        t_accum();
        t_full256();
        t_dither();
        t_auto();
        t_temp();
        t_alarm();
        end_of_test();
    end
endmodule
